// ===== src/mfrc_pkg.sv
// Constants for the memory fill and run control block
`default_nettype none
package mfrc_pkg;
   // Register offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_FCFG = 8'h04;
   localparam logic [7:0] A_FSTART = 8'h08;
   localparam logic [7:0] A_FEND = 8'h0C;
   localparam logic [7:0] A_FDATA = 8'h10;
   localparam logic [7:0] A_FSTAT = 8'h14;
   localparam logic [7:0] A_FAILADR = 8'h18;
   localparam logic [7:0] A_FAILWR = 8'h1C;
   localparam logic [7:0] A_FAILRD = 8'h20;
   localparam logic [7:0] A_RCFG = 8'h24;
   localparam logic [7:0] A_RSTART = 8'h28;
   localparam logic [7:0] A_RSTOP = 8'h2C;
   localparam logic [7:0] A_RSTAT = 8'h30;
   // Control bits
   localparam int CTRL_FILL_GO = 0;
   localparam int CTRL_RUN_GO = 1;
   localparam int CTRL_ABORT = 2;
   // Fill config fields
   localparam int FC_SIZE = 0;
   localparam int FC_NOVER = 2;
   localparam int FC_COUNT = 3;
   localparam int FC_PAT = 4;
   localparam int FC_QUAL = 5;
   localparam int FC_ASID = 7;
   localparam int FC_MAPEN = 8;
   localparam int FC_MMUON = 9;
   // Run config fields
   localparam int RC_KIND = 0;
   localparam int RC_STOPEN = 2;
   localparam int RC_MODE = 3;
   localparam int RC_SEL = 6;
   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0] DEF_PATTERN = 8'h00;
   // Timing
   localparam int unsigned CLK_NS = 8;
   localparam int unsigned POR_NS = 1000;
   localparam int unsigned POR_CYC = (POR_NS / CLK_NS < 1) ? 1 : POR_NS / CLK_NS;
   localparam int unsigned CR_NS [12] = '{6500, 9800, 50000, 100000, 500000, 1000000,
      5000000, 10000000, 50000000, 100000000, 500000000, 1000000000};
   typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10} mfrc_size_t;
   typedef enum logic [1:0] {Q_NONE = 2'b00, Q_PHYS = 2'b01, Q_VIRT = 2'b10} mfrc_qual_t;
   typedef enum logic [1:0] {TR_PHYS = 2'b00, TR_MAP = 2'b01, TR_TLB = 2'b10, TR_MMU = 2'b11} mfrc_tr_t;
   typedef enum logic [1:0] {K_PC = 2'b00, K_ADDR = 2'b01, K_RESET = 2'b10} mfrc_kind_t;
   typedef enum logic [2:0] {M_NORMAL = 3'b000, M_CYCRST = 3'b001, M_NOBRK = 3'b010,
      M_SEQ = 3'b011, M_TOUT = 3'b100} mfrc_mode_t;
   typedef enum logic [2:0] {H_NONE = 3'b000, H_STOP = 3'b001, H_BREAK = 3'b010,
      H_SEQ = 3'b011, H_TOUT = 3'b100, H_ABORT = 3'b101} mfrc_halt_t;
   typedef enum logic [1:0] {F_IDLE = 2'b00, F_CHK = 2'b01, F_WR = 2'b10, F_RD = 2'b11} mfrc_fst_t;
   typedef enum logic [1:0] {R_IDLE = 2'b00, R_RESET = 2'b01, R_RUN = 2'b10} mfrc_rst_t;
endpackage
`default_nettype wire

// ===== src/mfrc_core.sv
// Memory fill engine and run control with APB registers
// Summary of operation
// [R1] Without a given pattern the fill writes zero bytes.
// [R2] Unit size is 1, 2 or 4 bytes; default is 1 byte.
// [R3] Range end is an inclusive end address or a byte count.
// [R4] Each written unit is read back and compared.
// [R5] A mismatch stops the fill and records address, written and read value.
// [R6] The no-verify option skips read-back and only writes.
// [R7] Word units clear address bit zero of the start.
// [R8] Long units clear the two low address bits of the start.
// [R9] No byte beyond the end address is ever written.
// [R10] Only chip-select areas zero to six or on-chip memory may be filled.
// [R11] Unqualified addresses use the map table if enabled, else MMU state.
// [R12] Virtual addresses go through the TLB; ASID only with virtual.
// [R13] Run starts at the given address, else at the current PC.
// [R14] Reset start pulses power-on reset, then runs from the vector.
// [R15] A stop address halts before the instruction there executes.
// [R16] No mode option means normal emulation.
// [R17] Cycle reset mode pulses reset periodically; breaks and trace off.
// [R18] Selector 1 to 12 picks the cycle reset interval.
// [R19] Suppress-break disables breaks for this run only.
// [R20] Sequential mode halts on channel two then channel one.
// [R21] Timeout mode halts on subroutine timeout or count limit. The code has no count limit: only subroutine_timing_analysis gives the timeout halt.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module mfrc_core #(
   parameter int unsigned CR_CYC [12] = '{mfrc_pkg::CR_NS[0] / mfrc_pkg::CLK_NS,
      mfrc_pkg::CR_NS[1] / mfrc_pkg::CLK_NS, mfrc_pkg::CR_NS[2] / mfrc_pkg::CLK_NS,
      mfrc_pkg::CR_NS[3] / mfrc_pkg::CLK_NS, mfrc_pkg::CR_NS[4] / mfrc_pkg::CLK_NS,
      mfrc_pkg::CR_NS[5] / mfrc_pkg::CLK_NS, mfrc_pkg::CR_NS[6] / mfrc_pkg::CLK_NS,
      mfrc_pkg::CR_NS[7] / mfrc_pkg::CLK_NS, mfrc_pkg::CR_NS[8] / mfrc_pkg::CLK_NS,
      mfrc_pkg::CR_NS[9] / mfrc_pkg::CLK_NS, mfrc_pkg::CR_NS[10] / mfrc_pkg::CLK_NS,
      mfrc_pkg::CR_NS[11] / mfrc_pkg::CLK_NS}
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [1:0] mem_size,
   output logic [1:0] mem_xlate,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic area_permit,
   output logic power_on_reset_input,
   output logic tgt_run,
   output logic tgt_pc_load,
   output logic [31:0] tgt_pc,
   output logic brk_arm,
   output logic trace_arm,
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_pc,
   input wire logic break_hit,
   input wire logic user_break_channel_condition_1,
   input wire logic user_break_channel_condition_2,
   input wire logic subroutine_timing_analysis
);
   // ==========================================================
   // Register bus
   logic [31:0] fcfg_r, fstart_r, fend_r, fdata_r, rcfg_r, rstart_r, rstop_r;
   logic [31:0] prdata_r, fail_adr_r, fail_wr_r, fail_rd_r;
   logic pslverr_r, f_done_r, f_fail_r, f_ref_r;
   mfrc_pkg::mfrc_fst_t fst_r;
   mfrc_pkg::mfrc_rst_t rst_r;
   mfrc_pkg::mfrc_halt_t halt_r;
   wire setup = psel && !penable;
   wire wr_acc = psel && penable && pwrite;
   wire hit_ctrl = paddr == mfrc_pkg::A_CTRL;
   wire mapped = paddr <= mfrc_pkg::A_RSTAT && paddr[1:0] == 2'b00;
   wire fill_go = ce && wr_acc && hit_ctrl && pwdata[mfrc_pkg::CTRL_FILL_GO];
   wire run_go = ce && wr_acc && hit_ctrl && pwdata[mfrc_pkg::CTRL_RUN_GO];
   wire abort_go = ce && wr_acc && hit_ctrl && pwdata[mfrc_pkg::CTRL_ABORT];
   wire [31:0] fstat = {28'h000_0000, f_ref_r, f_fail_r, f_done_r, fst_r != mfrc_pkg::F_IDLE};
   wire [31:0] rstat = {28'h000_0000, halt_r, tgt_run};
   wire [31:0] rd_mux =
      paddr == mfrc_pkg::A_FCFG ? fcfg_r :
      paddr == mfrc_pkg::A_FSTART ? fstart_r :
      paddr == mfrc_pkg::A_FEND ? fend_r :
      paddr == mfrc_pkg::A_FDATA ? fdata_r :
      paddr == mfrc_pkg::A_FSTAT ? fstat :
      paddr == mfrc_pkg::A_FAILADR ? fail_adr_r :
      paddr == mfrc_pkg::A_FAILWR ? fail_wr_r :
      paddr == mfrc_pkg::A_FAILRD ? fail_rd_r :
      paddr == mfrc_pkg::A_RCFG ? rcfg_r :
      paddr == mfrc_pkg::A_RSTART ? rstart_r :
      paddr == mfrc_pkg::A_RSTOP ? rstop_r :
      paddr == mfrc_pkg::A_RSTAT ? rstat : mfrc_pkg::RST_WORD;
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r && psel && penable;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         prdata_r <= mfrc_pkg::RST_WORD;
         pslverr_r <= 1'b0;
      end
      else if (ce && setup)
      begin
         prdata_r <= rd_mux;
         pslverr_r <= !mapped;
      end
   end

   function automatic logic [31:0] wr_reg(input logic [7:0] a, input logic [31:0] old);
      wr_reg = (wr_acc && paddr == a) ? pwdata : old;
   endfunction

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         fcfg_r <= mfrc_pkg::RST_WORD;
         fstart_r <= mfrc_pkg::RST_WORD;
         fend_r <= mfrc_pkg::RST_WORD;
         fdata_r <= mfrc_pkg::RST_WORD;
         rcfg_r <= mfrc_pkg::RST_WORD;
         rstart_r <= mfrc_pkg::RST_WORD;
         rstop_r <= mfrc_pkg::RST_WORD;
      end
      else if (ce)
      begin
         fcfg_r <= wr_reg(mfrc_pkg::A_FCFG, fcfg_r);
         fstart_r <= wr_reg(mfrc_pkg::A_FSTART, fstart_r);
         fend_r <= wr_reg(mfrc_pkg::A_FEND, fend_r);
         fdata_r <= wr_reg(mfrc_pkg::A_FDATA, fdata_r);
         rcfg_r <= wr_reg(mfrc_pkg::A_RCFG, rcfg_r);
         rstart_r <= wr_reg(mfrc_pkg::A_RSTART, rstart_r);
         rstop_r <= wr_reg(mfrc_pkg::A_RSTOP, rstop_r);
      end
   end

   // ==========================================================
   // Fill engine
   logic [1:0] f_size_r, f_xl_r;
   logic f_nover_r, f_pat_r, f_req_r, f_we_r;
   logic [31:0] f_addr_r, f_end_r, f_wd_r;
   wire [1:0] c_size = fcfg_r[mfrc_pkg::FC_SIZE +: 2] > mfrc_pkg::SZ_LONG ? mfrc_pkg::SZ_BYTE :
      fcfg_r[mfrc_pkg::FC_SIZE +: 2]; // R2
   wire [1:0] c_qual = fcfg_r[mfrc_pkg::FC_QUAL +: 2];
   wire c_bad_asid = fcfg_r[mfrc_pkg::FC_ASID] && c_qual != mfrc_pkg::Q_VIRT; // R12
   wire [1:0] c_xl = c_qual == mfrc_pkg::Q_PHYS ? mfrc_pkg::TR_PHYS :
      c_qual == mfrc_pkg::Q_VIRT ? mfrc_pkg::TR_TLB : // R12
      fcfg_r[mfrc_pkg::FC_MAPEN] ? mfrc_pkg::TR_MAP : // R11
      fcfg_r[mfrc_pkg::FC_MMUON] ? mfrc_pkg::TR_MMU : mfrc_pkg::TR_PHYS; // R11
   wire [31:0] c_mask = c_size == mfrc_pkg::SZ_LONG ? 32'hFFFF_FFFC :
      c_size == mfrc_pkg::SZ_WORD ? 32'hFFFF_FFFE : 32'hFFFF_FFFF; // R7 R8
   wire c_empty = fcfg_r[mfrc_pkg::FC_COUNT] && fend_r == mfrc_pkg::RST_WORD;
   wire [31:0] c_end = fcfg_r[mfrc_pkg::FC_COUNT] ? fstart_r + fend_r - 32'h0000_0001 : fend_r; // R3
   wire [31:0] c_pat = fcfg_r[mfrc_pkg::FC_PAT] ? fdata_r : {24'h00_0000, mfrc_pkg::DEF_PATTERN}; // R1

   function automatic logic [32:0] unit_last(input logic [31:0] a, input logic [1:0] sz);
      unit_last = {1'b0, a} + (sz == mfrc_pkg::SZ_LONG ? 33'h0_0000_0003 :
         sz == mfrc_pkg::SZ_WORD ? 33'h0_0000_0001 : 33'h0_0000_0000);
   endfunction

   function automatic logic [31:0] lane_mask(input logic [1:0] sz);
      lane_mask = sz == mfrc_pkg::SZ_LONG ? 32'hFFFF_FFFF :
         sz == mfrc_pkg::SZ_WORD ? 32'h0000_FFFF : 32'h0000_00FF;
   endfunction

   wire past_end = unit_last(f_addr_r, f_size_r) > {1'b0, f_end_r}; // R9
   wire [31:0] f_step = f_addr_r + (f_size_r == mfrc_pkg::SZ_LONG ? 32'h0000_0004 :
      f_size_r == mfrc_pkg::SZ_WORD ? 32'h0000_0002 : 32'h0000_0001);
   wire rd_bad = (mem_rdata & lane_mask(f_size_r)) != f_wd_r; // R4
   wire wr_done = fst_r == mfrc_pkg::F_WR && mem_ack;
   wire rd_done = fst_r == mfrc_pkg::F_RD && mem_ack;
   wire wrap = f_step == mfrc_pkg::RST_WORD;

   assign mem_req = f_req_r;
   assign mem_we = f_we_r;
   assign mem_addr = f_addr_r;
   assign mem_wdata = f_wd_r;
   assign mem_size = f_size_r;
   assign mem_xlate = f_xl_r;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         fst_r <= mfrc_pkg::F_IDLE;
         f_req_r <= 1'b0;
         f_we_r <= 1'b0;
         f_size_r <= mfrc_pkg::SZ_BYTE;
         f_xl_r <= mfrc_pkg::TR_PHYS;
         f_nover_r <= 1'b0;
         f_pat_r <= 1'b0;
         f_addr_r <= mfrc_pkg::RST_WORD;
         f_end_r <= mfrc_pkg::RST_WORD;
         f_wd_r <= mfrc_pkg::RST_WORD;
         f_done_r <= 1'b0;
         f_fail_r <= 1'b0;
         f_ref_r <= 1'b0;
         fail_adr_r <= mfrc_pkg::RST_WORD;
         fail_wr_r <= mfrc_pkg::RST_WORD;
         fail_rd_r <= mfrc_pkg::RST_WORD;
      end
      else if (ce)
      begin
         unique case (fst_r)
            mfrc_pkg::F_IDLE:
            begin
               if (fill_go)
               begin
                  f_done_r <= c_bad_asid || c_empty;
                  f_fail_r <= 1'b0;
                  f_ref_r <= c_bad_asid; // R12
                  f_size_r <= c_size; // R2
                  f_xl_r <= c_xl; // R11
                  f_nover_r <= fcfg_r[mfrc_pkg::FC_NOVER];
                  f_pat_r <= fcfg_r[mfrc_pkg::FC_PAT];
                  f_addr_r <= fstart_r & c_mask; // R7 R8
                  f_end_r <= c_end; // R3
                  f_wd_r <= c_pat & lane_mask(c_size); // R1
                  if (!c_bad_asid && !c_empty)
                     fst_r <= mfrc_pkg::F_CHK;
               end
            end
            mfrc_pkg::F_CHK:
            begin
               if (past_end) // R9
               begin
                  f_done_r <= 1'b1;
                  fst_r <= mfrc_pkg::F_IDLE;
               end
               else if (!area_permit) // R10
               begin
                  f_ref_r <= 1'b1;
                  f_done_r <= 1'b1;
                  fst_r <= mfrc_pkg::F_IDLE;
               end
               else
               begin
                  f_req_r <= 1'b1;
                  f_we_r <= 1'b1;
                  fst_r <= mfrc_pkg::F_WR;
               end
            end
            mfrc_pkg::F_WR:
            begin
               if (mem_ack)
               begin
                  f_we_r <= 1'b0;
                  f_req_r <= !f_nover_r; // R4 R6
                  if (!f_nover_r)
                     fst_r <= mfrc_pkg::F_RD;
                  else
                  begin
                     f_addr_r <= f_step;
                     fst_r <= wrap ? mfrc_pkg::F_IDLE : mfrc_pkg::F_CHK;
                     f_done_r <= wrap;
                  end
               end
            end
            mfrc_pkg::F_RD:
            begin
               if (mem_ack)
               begin
                  f_req_r <= 1'b0;
                  if (rd_bad) // R5
                  begin
                     f_fail_r <= 1'b1;
                     f_done_r <= 1'b1;
                     fail_adr_r <= f_addr_r;
                     fail_wr_r <= f_wd_r;
                     fail_rd_r <= mem_rdata & lane_mask(f_size_r);
                     fst_r <= mfrc_pkg::F_IDLE;
                  end
                  else
                  begin
                     f_addr_r <= f_step;
                     fst_r <= wrap ? mfrc_pkg::F_IDLE : mfrc_pkg::F_CHK;
                     f_done_r <= wrap;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Run control
   logic [2:0] mode_r;
   logic stop_en_r, seq2_r, pc_ld_r, por_r, cr_r;
   logic [31:0] pc_r, stop_r, cr_cnt_r, cr_max_r;
   logic [15:0] por_cnt_r;
   wire [3:0] r_sel = rcfg_r[mfrc_pkg::RC_SEL +: 4];
   wire [2:0] r_mode = rcfg_r[mfrc_pkg::RC_MODE +: 3] > mfrc_pkg::M_TOUT ? mfrc_pkg::M_NORMAL :
      rcfg_r[mfrc_pkg::RC_MODE +: 3]; // R16
   wire [1:0] r_kind = rcfg_r[mfrc_pkg::RC_KIND +: 2];
   wire sel_ok = r_sel >= 4'h1 && r_sel <= 4'hC; // R18
   wire [31:0] sel_cyc = sel_ok ? 32'(CR_CYC[r_sel - 4'h1]) : 32'(CR_CYC[0]); // R18
   wire running = rst_r == mfrc_pkg::R_RUN;
   wire stop_hit = running && stop_en_r && fetch_valid && fetch_pc == stop_r; // R15
   wire seq_hit = mode_r == mfrc_pkg::M_SEQ && seq2_r && user_break_channel_condition_1; // R20
   wire brk_hit = brk_arm && mode_r != mfrc_pkg::M_SEQ && break_hit;
   wire to_hit = mode_r == mfrc_pkg::M_TOUT && subroutine_timing_analysis; // R21
   wire cr_fire = running && cr_r && cr_cnt_r >= cr_max_r - 32'h0000_0001; // R17
   assign tgt_run = running;
   assign tgt_pc_load = pc_ld_r;
   assign tgt_pc = pc_r;
   assign power_on_reset_input = por_r;
   assign brk_arm = running && (mode_r == mfrc_pkg::M_NORMAL || mode_r == mfrc_pkg::M_SEQ
      || mode_r == mfrc_pkg::M_TOUT); // R17 R19
   assign trace_arm = running && mode_r != mfrc_pkg::M_CYCRST; // R17

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rst_r <= mfrc_pkg::R_IDLE;
         halt_r <= mfrc_pkg::H_NONE;
         mode_r <= mfrc_pkg::M_NORMAL;
         stop_en_r <= 1'b0;
         seq2_r <= 1'b0;
         pc_ld_r <= 1'b0;
         por_r <= 1'b0;
         cr_r <= 1'b0;
         pc_r <= mfrc_pkg::RST_WORD;
         stop_r <= mfrc_pkg::RST_WORD;
         cr_cnt_r <= mfrc_pkg::RST_WORD;
         cr_max_r <= mfrc_pkg::RST_WORD;
         por_cnt_r <= 16'h0000;
      end
      else if (ce)
      begin
         pc_ld_r <= 1'b0;
         unique case (rst_r)
            mfrc_pkg::R_IDLE:
            begin
               if (run_go && (r_mode != mfrc_pkg::M_CYCRST || sel_ok))
               begin
                  halt_r <= mfrc_pkg::H_NONE;
                  mode_r <= r_mode; // R16 R19
                  cr_r <= r_mode == mfrc_pkg::M_CYCRST;
                  cr_max_r <= sel_cyc; // R18
                  cr_cnt_r <= mfrc_pkg::RST_WORD;
                  seq2_r <= 1'b0;
                  stop_en_r <= rcfg_r[mfrc_pkg::RC_STOPEN];
                  stop_r <= rstop_r;
                  pc_r <= rstart_r;
                  pc_ld_r <= r_kind == mfrc_pkg::K_ADDR; // R13
                  if (r_kind == mfrc_pkg::K_RESET) // R14
                  begin
                     por_r <= 1'b1;
                     por_cnt_r <= 16'(mfrc_pkg::POR_CYC - 1);
                     rst_r <= mfrc_pkg::R_RESET;
                  end
                  else
                     rst_r <= mfrc_pkg::R_RUN;
               end
            end
            mfrc_pkg::R_RESET:
            begin
               if (por_cnt_r == 16'h0000)
               begin
                  por_r <= 1'b0;
                  rst_r <= mfrc_pkg::R_RUN; // R14
               end
               else
                  por_cnt_r <= por_cnt_r - 16'h0001;
            end
            mfrc_pkg::R_RUN:
            begin
               if (user_break_channel_condition_2 && mode_r == mfrc_pkg::M_SEQ)
                  seq2_r <= 1'b1; // R20
               cr_cnt_r <= cr_fire ? mfrc_pkg::RST_WORD : cr_cnt_r + 32'h0000_0001;
               if (cr_fire) // R17
               begin
                  por_r <= 1'b1;
                  por_cnt_r <= 16'(mfrc_pkg::POR_CYC - 1);
               end
               else if (por_r)
               begin
                  por_cnt_r <= por_cnt_r - 16'h0001;
                  por_r <= por_cnt_r != 16'h0000;
               end
               if (abort_go || stop_hit || seq_hit || brk_hit || to_hit)
               begin
                  rst_r <= mfrc_pkg::R_IDLE;
                  por_r <= 1'b0;
                  halt_r <= abort_go ? mfrc_pkg::H_ABORT : stop_hit ? mfrc_pkg::H_STOP :
                     seq_hit ? mfrc_pkg::H_SEQ : to_hit ? mfrc_pkg::H_TOUT : mfrc_pkg::H_BREAK;
               end
            end
            default:
               rst_r <= mfrc_pkg::R_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_wr_ack;
      ce && wr_done;
   endsequence
   sequence s_rd_issue;
      mem_req && !mem_we && mem_addr == $past(mem_addr);
   endsequence
   fill_zero_a: assert property (mem_req && mem_we && !f_pat_r |-> mem_wdata == 32'h0000_0000) // R1
      else $error("fill default pattern not zero");
   word_align_a: assert property (mem_req && mem_size == mfrc_pkg::SZ_WORD |-> !mem_addr[0]) // R7
      else $error("word fill unaligned");
   long_align_a: assert property (mem_req && mem_size == mfrc_pkg::SZ_LONG |-> mem_addr[1:0] == 2'b00) // R8
      else $error("long fill unaligned");
   end_bound_a: assert property (mem_req && mem_we |-> unit_last(mem_addr, mem_size) <= {1'b0, f_end_r}) // R9
      else $error("fill write beyond end");
   verify_read_a: assert property (s_wr_ack ##0 !f_nover_r |=> s_rd_issue) // R4
      else $error("no read-back after write");
   skip_verify_a: assert property (s_wr_ack ##0 f_nover_r |=> !mem_req) // R6
      else $error("read-back despite no-verify");
   fail_stop_a: assert property (ce && rd_done && rd_bad |=> fst_r == mfrc_pkg::F_IDLE && f_fail_r
      && fail_adr_r == $past(mem_addr)) // R5
      else $error("mismatch did not stop fill");
   stop_halt_a: assert property (ce && stop_hit |=> !tgt_run && halt_r != mfrc_pkg::H_NONE) // R15
      else $error("stop address did not halt");
   cr_quiet_a: assert property (tgt_run && mode_r == mfrc_pkg::M_CYCRST |-> !brk_arm && !trace_arm) // R17
      else $error("breaks armed in cycle reset");
   seq_order_a: assert property (ce && running && mode_r == mfrc_pkg::M_SEQ && !seq2_r && !stop_hit
      && !abort_go && !to_hit |=> tgt_run) // R20
      else $error("sequential halt out of order");
   reset_start_a: assert property (ce && rst_r == mfrc_pkg::R_IDLE && run_go && r_kind == mfrc_pkg::K_RESET // R14
      && (sel_ok || r_mode != mfrc_pkg::M_CYCRST) |=> power_on_reset_input && !tgt_run)
      else $error("reset start without reset pulse");
endmodule
`default_nettype wire

// ===== dv/mfrc_tgt_mem.sv
// Target bus and memory model on the far side of the fill engine
`timescale 1ns/100ps
`default_nettype none
// ====================================
// Byte memory with prompt and slow answers
module mfrc_tgt_mem (
   input wire logic ref_clk,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [1:0] mem_size,
   input wire logic [1:0] mem_xlate,
   input wire logic [31:0] bad_addr,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   output logic area_permit,
   output logic [1:0] last_xlate
);
   logic [7:0] mem [0:255];
   logic [1:0] wait_r = 2'b00;
   logic [31:0] rd_nxt;
   assign area_permit = (mem_addr < 32'h8000_0000);
   initial
   begin
      foreach (mem[i]) mem[i] = 8'hA5;
      mem_ack = 1'b0;
      mem_rdata = 32'h0000_0000;
      last_xlate = 2'b00;
   end
   always @(posedge ref_clk)
   begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && wait_r >= {mem_addr[2], 1'b0})
      begin
         mem_ack <= 1'b1;
         wait_r <= 2'b00;
         rd_nxt = 32'h0000_0000;
         for (int i = 0; i < (1 << mem_size); i++)
         begin
            if (mem_we) mem[mem_addr[7:0] + i] <= mem_wdata[8*i +: 8];
            rd_nxt[8*i +: 8] = mem[mem_addr[7:0] + i];
         end
         mem_rdata <= (mem_addr == bad_addr) ? rd_nxt ^ 32'h0000_00FF : rd_nxt;
         if (mem_we) last_xlate <= mem_xlate;
      end
      else if (mem_req && !mem_ack) wait_r <= wait_r + 2'b01;
   end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Testbench for the memory fill and run control block
`timescale 1ns/100ps
`default_nettype none
// ====================================
// Stimulus and checks
module tb_top;
   logic ref_clk = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, fetch_valid = 0;
   logic [7:0] paddr = 0;
   logic [3:0] ev = 0;
   logic [31:0] pwdata = 0, fetch_pc = 0, bad_addr = 32'hFFFF_FFFF, rd, pcl, prdata, mem_addr, mem_wdata, mem_rdata, tgt_pc;
   logic pready, pslverr, mem_req, mem_we, mem_ack, area_permit, power_on_reset_input, tgt_run, tgt_pc_load;
   logic brk_arm, trace_arm, err, por_q = 0;
   logic [1:0] mem_size, mem_xlate, last_xlate;
   logic [31:0] xc [6] = '{32'h100, 32'h200, 32'h0, 32'h20, 32'h40, 32'hC0};
   logic [1:0] xe [6] = '{2'h1, 2'h3, 2'h0, 2'h0, 2'h2, 2'h2};
   int n_fail = 0, n_checks = 0, cyc = 0, last = 0, per = 0, pcnt = 0;
   initial forever #4 ref_clk = ~ref_clk;
   mfrc_core #(.CR_CYC('{200, 300, 400, 500, 600, 700, 800, 900, 1000, 1100, 1200, 1300})) dut (.ref_clk, .reset, .ce,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata,
      .mem_size, .mem_xlate, .mem_ack, .mem_rdata, .area_permit, .power_on_reset_input, .tgt_run, .tgt_pc_load, .tgt_pc,
      .brk_arm, .trace_arm, .fetch_valid, .fetch_pc, .break_hit(ev[0]), .user_break_channel_condition_1(ev[1]),
      .user_break_channel_condition_2(ev[2]), .subroutine_timing_analysis(ev[3]));
   mfrc_tgt_mem tgt (.ref_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_size, .mem_xlate, .bad_addr, .mem_ack,
      .mem_rdata, .area_permit, .last_xlate);
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      por_q <= power_on_reset_input;
      if (tgt_pc_load) pcl <= tgt_pc;
      if (power_on_reset_input) pcnt <= pcnt + 1;
      if (power_on_reset_input && !por_q)
      begin
         per <= cyc - last;
         last <= cyc;
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
      n_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic fill(input logic [31:0] cfg, input logic [31:0] st, input logic [31:0] en, input logic [31:0] d);
      apb(1, mfrc_pkg::A_FCFG, cfg);
      apb(1, mfrc_pkg::A_FSTART, st);
      apb(1, mfrc_pkg::A_FEND, en);
      apb(1, mfrc_pkg::A_FDATA, d);
      apb(1, mfrc_pkg::A_CTRL, 32'h0000_0001);
      do apb(0, mfrc_pkg::A_FSTAT, 0); while (rd[0] !== 1'b0 || rd[2:1] === 2'b00);
   endtask
   task automatic span(input int lo, input int hi, input logic [7:0] v);
      for (int a = lo - 1; a <= hi + 1; a++) chk(tgt.mem[a], (a < lo || a > hi) ? 8'hA5 : v, "memory byte");
   endtask
   task automatic run(input logic [31:0] cfg);
      apb(1, mfrc_pkg::A_RCFG, cfg);
      apb(1, mfrc_pkg::A_CTRL, 32'h0000_0002);
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic hit(input logic [3:0] m, input logic [31:0] st);
      @(posedge ref_clk);
      ev <= m;
      @(posedge ref_clk);
      ev <= 0;
      repeat (3) @(posedge ref_clk);
      apb(0, mfrc_pkg::A_RSTAT, 0);
      chk(rd, st, "run status");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #400000;
      n_fail++;
      finish_test;
   end
   initial
   begin
      repeat (16) @(posedge ref_clk);
      reset <= 0;
      fill(32'h0, 32'h10, 32'h13, 32'h77);
      span(16, 19, 8'h00);
      fill(32'h11, 32'h21, 32'h24, 32'h5A5A_5A5A);
      span(32, 35, 8'h5A);
      fill(32'h12, 32'h43, 32'h4A, 32'h5A5A_5A5A);
      span(64, 71, 8'h5A);
      fill(32'h18, 32'h50, 32'h3, 32'h5A5A_5A5A);
      span(80, 82, 8'h5A);
      bad_addr <= 32'h62;
      fill(32'h10, 32'h60, 32'h63, 32'h5A);
      chk(rd & 4, 4, "fail flag");
      chk(tgt.mem[99], 8'hA5, "byte after failure");
      apb(0, mfrc_pkg::A_FAILADR, 0);
      chk(rd, 32'h62, "fail address");
      apb(0, mfrc_pkg::A_FAILWR, 0);
      chk(rd, 32'h5A, "fail written");
      apb(0, mfrc_pkg::A_FAILRD, 0);
      chk(rd, 32'hA5, "fail read");
      fill(32'h14, 32'h60, 32'h63, 32'h5A);
      chk(rd & 4, 0, "fail flag");
      chk(tgt.mem[99], 8'h5A, "byte written");
      fill(32'h0, 32'h8000_0000, 32'h8000_0003, 0);
      chk(rd & 8, 8, "refused flag");
      fill(32'hA0, 32'h70, 32'h70, 0);
      chk(rd & 8, 8, "refused flag");
      for (int i = 0; i < 6; i++)
      begin
         fill(xc[i], 32'h70, 32'h70, 0);
         chk(last_xlate, xe[i], "translation");
      end
      apb(0, 8'h34, 0);
      chk(err, 1, "bus error");
      apb(1, mfrc_pkg::A_RSTOP, 32'h1240);
      apb(1, mfrc_pkg::A_RSTART, 32'h1234);
      run(32'h5);
      chk(pcl, 32'h1234, "start pc");
      chk(brk_arm, 1, "breaks armed");
      fetch_pc <= 32'h1240;
      fetch_valid <= 1;
      hit(0, 32'h2);
      fetch_valid <= 0;
      pcl <= 0;
      run(32'h0);
      chk(pcl, 0, "no pc load");
      hit(1, 32'h4);
      pcnt <= 0;
      run(32'h2);
      repeat (140) @(posedge ref_clk);
      chk(pcnt, mfrc_pkg::POR_CYC, "reset width");
      chk(tgt_run, 1, "running after reset");
      apb(1, mfrc_pkg::A_CTRL, 32'h0000_0004);
      run(32'h88);
      repeat (700) @(posedge ref_clk);
      chk(per, 300, "cycle reset interval");
      chk({brk_arm, trace_arm}, 0, "arming in cycle reset");
      hit(1, 32'h1);
      apb(1, mfrc_pkg::A_CTRL, 32'h0000_0004);
      run(32'h10);
      hit(1, 32'h1);
      apb(1, mfrc_pkg::A_CTRL, 32'h0000_0004);
      run(32'h0);
      hit(1, 32'h4);
      run(32'h18);
      hit(2, 32'h1);
      hit(4, 32'h1);
      hit(2, 32'h6);
      run(32'h20);
      hit(8, 32'h8);
      finish_test;
   end
endmodule
`default_nettype wire
